// [verilog/wtm_defs.svh]
// register offsets, field positions, reset values and counts for the watchdog/tick/monitor
`ifndef WTM_DEFS_SVH
`define WTM_DEFS_SVH
`define WTM_ADDR_W          8
`define WTM_OFS_TICK_CTL    8'h14
`define WTM_OFS_TICK_FLAG   8'h15
`define WTM_OFS_WD_CTL      8'h16
`define WTM_OFS_SERVICE     8'h17
`define WTM_SVC_FIRST       8'h55
`define WTM_SVC_SECOND      8'haa
`define WTM_ZERO8           8'h00
`define WTM_TICK_CTL_RST    8'h00
`define WTM_WD_CTL_RST_NRM  8'h07
`define WTM_WD_CTL_RST_SPC  8'h0f
`define WTM_BIT7            7
`define WTM_BIT6            6
`define WTM_BIT5            5
`define WTM_BIT4            4
`define WTM_BIT3            3
`define WTM_RATE_OFF        3'h0
`define WTM_TICK_BASE_EXP   5'd12
`define WTM_BYP_EXP         5'd0
`define WTM_DIV_W           24
`define WTM_MON_TIMEOUT_NS  2000
`define WTM_CLK_PERIOD_NS   5
`define WTM_MON_CYCLES      ((`WTM_MON_TIMEOUT_NS + `WTM_CLK_PERIOD_NS - 1) / `WTM_CLK_PERIOD_NS)
`endif

// [verilog/wtm_pkg.sv]
// types shared by the watchdog/tick/monitor block
package wtm_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wtm_bus_t;

  typedef struct packed {
    logic wd_reset;
    logic mon_reset;
    logic limp_home;
  } wtm_rst_t;
endpackage

// [verilog/wtm_top.sv]
// watchdog, periodic tick and reference clock monitor
`timescale 1ns/100ps
`default_nettype none
`include "wtm_defs.svh"

module wtm_top #(
  parameter int MON_CYCLES = `WTM_MON_CYCLES
) (
  input  wire logic            i_clk_sys,
  input  wire logic            i_sys_rst,
  input  wire wtm_pkg::wtm_bus_t i_bus,
  input  wire logic            i_special_mode,
  input  wire logic            i_divided_crystal_clock_tick,
  input  wire logic            i_reference_clock,
  input  wire logic            i_pll_supply_status,
  input  wire logic            i_cpu_wait,
  input  wire logic            i_cpu_debug,
  input  wire logic            i_no_limp_home,
  output logic [7:0]           o_rdata,
  output logic                 o_tick_irq,
  output wtm_pkg::wtm_rst_t    o_rst_req
);
  import wtm_pkg::*;

  typedef struct packed {
    logic [7:0]          tick_ctl;
    logic                tick_flag;
    logic [7:0]          wd_ctl;
    logic [5:0]          lock;      // write-once locks: swai,sbck,monitor_force_enable,window_watchdog,rate,init
    logic                armed;     // first service value seen
    logic [`WTM_DIV_W-1:0] wd_cnt;
    logic [`WTM_DIV_W-1:0] tk_cnt;
    logic [2:0]          ref_sync;
    logic                ref_last;
    logic [15:0]         mon_cnt;
    logic                pll_cap;
    logic [7:0]          rdata;
    wtm_rst_t            rst;
  } wtm_state_t;

  wtm_state_t st;
  wtm_state_t next_st;

  // watchdog period exponent per rate code
  function automatic logic [4:0] wd_exp(input logic [2:0] code);
    logic [4:0] e;
    e = 5'd0;
    unique case (code)
      3'd1: e = 5'd13;
      3'd2: e = 5'd15;
      3'd3: e = 5'd17;
      3'd4: e = 5'd19;
      3'd5: e = 5'd21;
      3'd6: e = 5'd22;
      3'd7: e = 5'd23;
      3'd0: e = 5'd0;
    endcase
    return e;
  endfunction

  // one-hot mask for a power of two
  function automatic logic [`WTM_DIV_W-1:0] pow2(input logic [4:0] e);
    return `WTM_DIV_W'(1) << e;
  endfunction

  logic       wr_tc;
  logic       wr_tf;
  logic       wr_wc;
  logic       wr_sv;
  logic       halted;
  logic       wd_on;
  logic       mon_on;
  logic [4:0] tk_e;
  logic [4:0] we;
  logic       wd_expired;
  logic       in_window;
  logic       tick_hit;
  logic       ref_edge;
  logic       mon_fail;
  logic       wd_fail;
  logic       force_wd;
  logic       force_mon;
  logic       nrm;

  // decode and derived conditions
  always_comb begin
    nrm      = ~i_special_mode;
    wr_tc    = i_bus.wr && (i_bus.addr == `WTM_OFS_TICK_CTL);
    wr_tf    = i_bus.wr && (i_bus.addr == `WTM_OFS_TICK_FLAG);
    wr_wc    = i_bus.wr && (i_bus.addr == `WTM_OFS_WD_CTL);
    wr_sv    = i_bus.wr && (i_bus.addr == `WTM_OFS_SERVICE);
    halted   = (st.tick_ctl[`WTM_BIT6] && i_cpu_wait)
             || (st.tick_ctl[`WTM_BIT5] && i_cpu_debug);
    we       = wd_exp(st.wd_ctl[2:0]);
    wd_on    = st.wd_ctl[2:0] != `WTM_RATE_OFF;
    mon_on   = st.wd_ctl[`WTM_BIT6] || st.wd_ctl[`WTM_BIT7];
    // bypass swaps the 2^12 base stage for a divide by one
    tk_e     = st.tick_ctl[`WTM_BIT3] ? 5'(`WTM_BYP_EXP + {2'b00, st.tick_ctl[2:0]})
             : 5'(`WTM_TICK_BASE_EXP + {2'b00, st.tick_ctl[2:0]});
    wd_expired = wd_on && (st.wd_cnt == pow2(we) - `WTM_DIV_W'(1));
    // last quarter: count at or above three quarters of the period
    in_window = st.wd_cnt >= (pow2(we) - (pow2(we) >> 2));
    tick_hit = (st.tick_ctl[2:0] != `WTM_RATE_OFF) && i_divided_crystal_clock_tick && !halted
             && (st.tk_cnt[tk_e -: 1] == 1'b1)
             && ((st.tk_cnt & (pow2(tk_e) - `WTM_DIV_W'(1))) == '0) && (st.tk_cnt != '0);
    // a level counts once the last two sync stages agree
    ref_edge = (st.ref_sync[2] == st.ref_sync[1]) && (st.ref_sync[2] != st.ref_last);
    mon_fail = mon_on && (st.mon_cnt >= 16'(MON_CYCLES));
    wd_fail  = wd_on && (wd_expired && i_divided_crystal_clock_tick && !halted
             || wr_sv && (i_bus.wdata != `WTM_SVC_FIRST && i_bus.wdata != `WTM_SVC_SECOND)
             || wr_sv && st.wd_ctl[`WTM_BIT4] && !in_window);
    force_mon = st.wd_ctl[`WTM_BIT5] && mon_on;
    force_wd  = st.wd_ctl[`WTM_BIT5] && wd_on && !force_mon;
  end

  // next state
  always_comb begin
    next_st = st;
    next_st.ref_sync = {st.ref_sync[1:0], i_reference_clock};
    next_st.ref_last = ref_edge ? st.ref_sync[2] : st.ref_last;
    next_st.pll_cap = i_pll_supply_status;
    next_st.rst = '0;
    next_st.rdata = `WTM_ZERO8;
    // monitor edge watch
    if (ref_edge || !mon_on) begin
      next_st.mon_cnt = '0;
    end else if (st.mon_cnt < 16'(MON_CYCLES)) begin
      next_st.mon_cnt = st.mon_cnt + 16'd1;
    end
    // tick divider and flag
    if (i_divided_crystal_clock_tick && !halted) begin
      next_st.tk_cnt = st.tk_cnt + `WTM_DIV_W'(1);
      if (wd_on) begin
        next_st.wd_cnt = wd_expired ? '0 : st.wd_cnt + `WTM_DIV_W'(1);
      end
    end
    if (wr_tf && i_bus.wdata[`WTM_BIT7]) begin
      next_st.tick_flag = 1'b0;
    end
    if (tick_hit) begin
      next_st.tick_flag = 1'b1;
    end
    // tick control writes
    if (wr_tc) begin
      next_st.tick_ctl[7] = i_bus.wdata[7];
      next_st.tick_ctl[2:0] = i_bus.wdata[2:0];
      if (!nrm || !st.lock[0]) begin
        next_st.tick_ctl[6] = i_bus.wdata[6];
        next_st.lock[0] = nrm;
      end
      if (!nrm || !st.lock[1]) begin
        next_st.tick_ctl[5] = i_bus.wdata[5];
        next_st.lock[1] = nrm;
      end
      if (!nrm) begin
        next_st.tick_ctl[3] = i_bus.wdata[3];
      end
    end
    // watchdog control writes
    if (wr_wc) begin
      next_st.wd_ctl[7] = i_bus.wdata[7];
      if (!nrm || !st.lock[2]) begin
        next_st.wd_ctl[6] = i_bus.wdata[6];
        next_st.lock[2] = nrm;
      end
      if (!nrm) begin
        next_st.wd_ctl[5] = i_bus.wdata[5];
        next_st.wd_ctl[3] = i_bus.wdata[3];
      end
      if (!nrm || !st.lock[3]) begin
        next_st.wd_ctl[4] = i_bus.wdata[4];
        next_st.lock[3] = nrm;
      end
      if (!nrm || !st.lock[4]) begin
        next_st.wd_ctl[2:0] = i_bus.wdata[2:0];
        next_st.lock[4] = nrm;
        next_st.wd_cnt = '0;
      end
    end
    // service sequence
    if (wr_sv && i_bus.wdata == `WTM_SVC_FIRST) begin
      next_st.armed = 1'b1;
    end
    if (wr_sv && i_bus.wdata == `WTM_SVC_SECOND && st.armed) begin
      next_st.armed = 1'b0;
      next_st.wd_cnt = '0;
    end
    // reset requests, blocked by reset-disable
    if (!st.wd_ctl[`WTM_BIT3]) begin
      next_st.rst.wd_reset = wd_fail || force_wd;
      next_st.rst.mon_reset = (mon_fail && i_no_limp_home) || force_mon;
      next_st.rst.limp_home = mon_fail && !i_no_limp_home && !force_mon;
    end
    // read data, one cycle later
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        `WTM_OFS_TICK_CTL:  next_st.rdata = st.tick_ctl;
        `WTM_OFS_TICK_FLAG: next_st.rdata = {st.tick_flag, 7'h00};
        `WTM_OFS_WD_CTL:    next_st.rdata = st.wd_ctl;
        default:            next_st.rdata = `WTM_ZERO8;
      endcase
    end
    // strap capture after reset release
    if (!st.lock[5]) begin
      next_st.lock[5] = 1'b1;
      next_st.wd_ctl[7] = st.pll_cap;
    end
  end

  // state register
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st <= '0;
      st.tick_ctl <= `WTM_TICK_CTL_RST;
      st.pll_cap <= i_pll_supply_status;   // supply level for the enable strap
      st.wd_ctl <= `WTM_WD_CTL_RST_NRM;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_tick_irq = st.tick_flag && st.tick_ctl[`WTM_BIT7];
  assign o_rst_req = st.rst;

  property p_bad_value;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (wr_sv && wd_on && !st.wd_ctl[3] && i_bus.wdata != `WTM_SVC_FIRST
       && i_bus.wdata != `WTM_SVC_SECOND) |=> o_rst_req.wd_reset;
  endproperty
  a_bad_value: assert property (p_bad_value) else $error("bad service value no reset");

  property p_irq;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (tick_hit && st.tick_ctl[`WTM_BIT7] && !wr_tc) |=> o_tick_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("tick irq mismatch");

  property p_reset_disable;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      $past(st.wd_ctl[3]) |-> !o_rst_req.wd_reset && !o_rst_req.mon_reset;
  endproperty
  a_reset_disable: assert property (p_reset_disable) else $error("reset while disabled");

  property p_prio;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      !(o_rst_req.mon_reset && o_rst_req.wd_reset && $past(st.wd_ctl[5]) && !$past(wd_fail));
  endproperty
  a_prio: assert property (p_prio) else $error("both forced resets");

  property p_flag_clr;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (wr_tf && i_bus.wdata[7] && !tick_hit) |=> !st.tick_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

  property p_flag_set;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      tick_hit |=> st.tick_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_restart;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (wr_sv && i_bus.wdata == `WTM_SVC_SECOND && st.armed) |=> st.wd_cnt == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");

  property p_bypass_lock;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (wr_tc && nrm) |=> $stable(st.tick_ctl[3]);
  endproperty
  a_bypass_lock: assert property (p_bypass_lock) else $error("bypass written in normal");

  property p_halt;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (halted && !wr_sv && !wr_wc) |=> $stable(st.wd_cnt);
  endproperty
  a_halt: assert property (p_halt) else $error("watchdog ran while halted");
endmodule
`default_nettype wire

// [verif/tb_wtm_top.sv]
// self-checking bench for the watchdog, tick and clock monitor block
`timescale 1ns/100ps
`default_nettype none
`include "wtm_defs.svh"
module tb_wtm_top;
  import wtm_pkg::*;
  localparam logic [7:0] TC = `WTM_OFS_TICK_CTL;
  localparam logic [7:0] TF = `WTM_OFS_TICK_FLAG;
  localparam logic [7:0] WC = `WTM_OFS_WD_CTL;
  localparam logic [7:0] SV = `WTM_OFS_SERVICE;
  logic       clk, rst, spc, wt, ref_clk, ref_run, nolh, irq;
  logic       ref_ph, dbg;
  wtm_bus_t   bus;
  wtm_rst_t   rq;
  logic [7:0] rdata;
  int         mismatches, n_checks, n;
  // monitor delay shortened so a stopped reference shows quickly
  wtm_top #(.MON_CYCLES(8)) DUT (.i_clk_sys(clk), .i_sys_rst(rst), .i_bus(bus),
    .i_special_mode(spc), .i_divided_crystal_clock_tick(1'b1), .i_reference_clock(ref_clk),
    .i_pll_supply_status(1'b1), .i_cpu_wait(wt), .i_cpu_debug(dbg),
    .i_no_limp_home(nolh), .o_rdata(rdata), .o_tick_irq(irq), .o_rst_req(rq));
  // system clock, 5 ns
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // reference clock changes every second cycle while running
  always @(posedge clk) begin
    if (ref_run) begin
      ref_ph  <= ~ref_ph;
      ref_clk <= ref_ph ? ~ref_clk : ref_clk;
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 chk(rdata, exp);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: pick = rq.wd_reset;
      1: pick = rq.mon_reset;
      2: pick = rq.limp_home;
      default: pick = irq;
    endcase
  endfunction
  // bounded wait for an output, cycles counted in cnt
  task automatic wait_sig(input int s, input int lim, output int cnt);
    for (cnt = 0; cnt < lim; cnt++) begin
      #1;
      if (pick(s) === 1'b1) return;
      @(posedge clk);
    end
    mismatches++;
    $display("BAD t=%0t seen=%h exp=%h", $time, 8'h00, 8'h01);
    complete_run;
  endtask
  task automatic reset_dut;
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    mismatches = 0;
    n_checks = 0;
    rst = 1'b1;
    spc = 1'b0;
    wt = 1'b0;
    ref_clk = 1'b0;
    ref_ph = 1'b0;
    dbg = 1'b0;
    ref_run = 1'b1;
    nolh = 1'b1;
    bus = '0;
    reset_dut;
    // reset values, then write-once and no-write bits in normal mode
    rd(TC, 8'h00);
    rd(TF, 8'h00);
    rd(WC, 8'h87);
    rd(SV, 8'h00);
    wr(WC, 8'h02);
    wr(WC, 8'h8b);
    rd(WC, 8'h82);
    // good pair, then a stray service value
    wr(SV, `WTM_SVC_FIRST);
    wr(SV, `WTM_SVC_SECOND);
    wr(SV, 8'h12);
    wait_sig(0, 4, n);
    chk(8'(n <= 2), 8'h01);
    // rate code one times out after 2^13 divided clocks
    reset_dut;
    wr(WC, 8'h81);
    wr(SV, `WTM_SVC_FIRST);
    wr(SV, `WTM_SVC_SECOND);
    wait_sig(0, 9000, n);
    chk(8'(n >= 8100 && n <= 8300), 8'h01);
    // early service in window mode
    reset_dut;
    wr(WC, 8'h91);
    wr(SV, `WTM_SVC_FIRST);
    wait_sig(0, 4, n);
    chk(8'(n <= 2), 8'h01);
    // tick halted in wait, then in debug, then runs at 2^13
    reset_dut;
    wt <= 1'b1;
    wr(TC, 8'he1);
    repeat (4500) @(posedge clk);
    wt  <= 1'b0;
    dbg <= 1'b1;
    repeat (4500) @(posedge clk);
    rd(TF, 8'h00);
    dbg <= 1'b0;
    wait_sig(3, 9000, n);
    chk(8'(n >= 8100 && n <= 8300), 8'h01);
    rd(TF, 8'h80);
    wr(TC, 8'h41);
    @(posedge clk);
    #1 chk({7'h00, irq}, 8'h00);
    wr(TF, 8'h80);
    rd(TF, 8'h00);
    // stopped reference: reset request, then limp-home
    for (int v = 1; v >= 0; v--) begin
      nolh <= v[0];
      ref_run <= 1'b1;
      reset_dut;
      repeat (20) @(posedge clk);
      #1 chk({5'h00, rq}, 8'h00);
      ref_run <= 1'b0;
      wait_sig(v == 1 ? 1 : 2, 20, n);
      chk(8'(n < 20), 8'h01);
    end
    // forced failure in special mode, then masked by reset-disable
    nolh <= 1'b1;
    ref_run <= 1'b1;
    spc <= 1'b1;
    reset_dut;
    wr(WC, 8'ha1);
    repeat (3) @(posedge clk);
    #1 chk({6'h00, rq.wd_reset, rq.mon_reset}, 8'h01);
    wr(WC, 8'h21);
    repeat (3) @(posedge clk);
    #1 chk({6'h00, rq.wd_reset, rq.mon_reset}, 8'h02);
    wr(WC, 8'ha9);
    repeat (3) @(posedge clk);
    #1 chk({5'h00, rq}, 8'h00);
    complete_run;
  end
endmodule
`default_nettype wire
